// ### msp_regs.svh
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH

// register byte addresses
`define MSP_A_RATED_CUR 8'h00
`define MSP_A_NOLOAD 8'h04
`define MSP_A_SLIP 8'h08
`define MSP_A_GAIN 8'h0C
`define MSP_A_SLIP_TC 8'h10
`define MSP_A_MIN_FREQ 8'h14
`define MSP_A_CURVE 8'h18
`define MSP_A_THERM_TC 8'h1C
`define MSP_A_OH_ACT 8'h20
`define MSP_A_FILT_TC 8'h24
`define MSP_A_FREF 8'h28
`define MSP_A_PID 8'h2C
`define MSP_A_PID_FB 8'h30
`define MSP_A_STATUS 8'h34
`define MSP_A_SRC 8'h38
`define MSP_A_THERM_V 8'h3C
`define MSP_A_HEAT 8'h40

// status bit positions
`define MSP_ST_CONFLICT 3
`define MSP_ST_KEY 4

// reset values
`define MSP_RST_SLIP_TC 8'h14
`define MSP_RST_THERM_TC 6'h08
`define MSP_RST_FILT_TC 7'h02
`define MSP_RST_FREF 4'h1

// limits and scaling
`define MSP_SLIP_TC_ZERO 8'h14
`define MSP_NOLOAD_MAX 8'h63
`define MSP_THERM_TC_MAX 6'h3C
`define MSP_FILT_TC_MAX 7'h64
`define MSP_TICKS_PER_MIN 16'h0258
`define MSP_LIM_GP 12'h0F0
`define MSP_LIM_INV 12'h130
`define MSP_RATIO_MAX 10'h3FF

// timing
`define MSP_CLK_HZ 125000000
`define MSP_TICK_MS 100
`define MSP_FLASH_TICKS 3'h5

// thermistor thresholds in millivolts
`define MSP_OH_ALARM_MV 940
`define MSP_OH_FAULT_MV 1870

`endif

// ### msp_pkg.sv
package msp_pkg;

   typedef enum logic [1:0] {
      MSP_CURVE_GP,
      MSP_CURVE_INV,
      MSP_CURVE_OFF
   } msp_curve_t;

   typedef struct packed {
      logic [15:0] rated_cur;
      logic [7:0] noload_pct;
      logic [7:0] rated_slip;
      logic [7:0] slip_gain;
      logic [7:0] slip_tc;
      logic [15:0] min_freq;
      msp_curve_t curve;
      logic [5:0] therm_tc;
      logic [2:0] oh_action;
      logic [6:0] filt_tc;
      logic [3:0] fref_sel;
      logic [3:0] pid_sel;
      logic [3:0] pid_fb_sel;
   } msp_cfg_t;

endpackage

// ### msp_top.sv
// Function
// - at rated current add full slip compensation; scale with load above no-load.
// - no slip compensation below minimum output frequency.
// - no slip compensation while regenerating.
// - no slip compensation when rated current setting is zero.
// - zero rated current disables thermal overload protection.
// - curve code 0 general motor, 1 inverter motor, 2 protection off.
// - thermal model integrates the square of current over time, time constant in minutes.
// - overload trips the overload fault and switches the output off.
// - filtered thermistor above 0.94 V raises flashing overheat alarm.
// - filtered thermistor above 1.87 V raises flashing fault and stops as selected.
// - overheat action zero disables thermistor protection.
// - code 1 alarm only; 2,3 alarm and decel; 5,6 decel without alarm.
// - code 3 decelerates using the second deceleration time.
// - code 4 alarm and coast; code 7 coast without alarm.
// - thermistor first-order filter, 0.1 s units, up to 10.0 s, default 0.2 s.
// - thermistor protection excludes the shared input as reference or feedback.
// - keypad forbidden write shows an error and keeps the old value.
// - serial forbidden write raises a flashing constant setting error.
// - with thermistor on, reject reference codes 2, 3 and 4.
// - with thermistor and PID on, reject feedback codes 0, 1, 2.
// - reject thermistor enable while analog reference or analog feedback used.
`timescale 1ns/100ps
`default_nettype none
`include "msp_regs.svh"

module msp_top #(
   parameter int ADC_W = 12,
   parameter int ADC_FS_MV = 10000,
   parameter int TICK_CYC = `MSP_CLK_HZ / 1000 * `MSP_TICK_MS,
   parameter logic [15:0] DEF_RATED_CUR = 16'h0000,
   parameter logic [7:0] DEF_NOLOAD = 8'h00,
   parameter logic [7:0] DEF_SLIP = 8'h00
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] out_freq_i,
   input wire logic [15:0] out_cur_i,
   input wire logic regen_i,
   input wire logic [ADC_W-1:0] thermistor_analog_input_i,
   input wire logic fault_reset_i,
   output logic [15:0] comp_freq_o,
   output logic [15:0] slip_comp_o,
   output logic output_off_o,
   output logic decel_stop_o,
   output logic use_second_decel_o,
   output logic motor_overload_fault_o,
   output logic motor_overheat_alarm_o,
   output logic motor_overheat_fault_o,
   output logic alarm_flash_o,
   output logic fault_flash_o,
   output logic constant_conflict_error_o,
   output logic conflict_flash_o,
   output logic key_error_o
);

   if (ADC_W < 8 || ADC_W > 16 || TICK_CYC < 2 || ADC_FS_MV < 2000) begin : g_bad
      $error("msp_top: unsupported parameters");
   end

   localparam int THR_MAX = (1 << ADC_W) - 1;
   localparam logic [ADC_W-1:0] ALM_THR =
      ADC_W'(`MSP_OH_ALARM_MV * THR_MAX / ADC_FS_MV);
   localparam logic [ADC_W-1:0] FLT_THR =
      ADC_W'(`MSP_OH_FAULT_MV * THR_MAX / ADC_FS_MV);

   msp_pkg::msp_cfg_t cfg;
   logic serial_src;

   // 0.1 s time base

   logic [31:0] tick_cnt;
   logic tick;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt <= 32'h0;
         tick <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
         tick_cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   // bus decode and interlocks

   logic req;
   logic wr;
   logic [7:0] wd;
   logic therm_on;
   logic bad;

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr = req & wb_we_i & wb_sel_i[0];
   assign wd = wb_dat_i[7:0];
   assign therm_on = cfg.oh_action != 3'h0;

   function automatic logic analog_ref(input logic [3:0] v);
      return v >= 4'h2 && v <= 4'h4;
   endfunction

   function automatic logic analog_fb(input logic [3:0] v);
      return v <= 4'h2;
   endfunction

   always_comb begin
      bad = 1'b0;
      case (wb_adr_i)
         `MSP_A_FREF: begin
            bad = therm_on && analog_ref(wd[3:0]);
         end
         `MSP_A_PID_FB: begin
            bad = therm_on && cfg.pid_sel != 4'h0 && analog_fb(wd[3:0]);
         end
         `MSP_A_PID: begin
            bad = therm_on && wd[3:0] != 4'h0 && analog_fb(cfg.pid_fb_sel);
         end
         `MSP_A_OH_ACT: begin
            bad = wd[2:0] != 3'h0 && (analog_ref(cfg.fref_sel) ||
               (cfg.pid_sel != 4'h0 && analog_fb(cfg.pid_fb_sel)));
         end
         default: bad = 1'b0;
      endcase
   end

   logic ok_wr;
   assign ok_wr = wr & ~bad;

   // configuration store; a refused write leaves the old value
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg.rated_cur <= DEF_RATED_CUR;
         cfg.noload_pct <= DEF_NOLOAD;
         cfg.rated_slip <= DEF_SLIP;
         cfg.slip_gain <= 8'h00;
         cfg.slip_tc <= `MSP_RST_SLIP_TC;
         cfg.min_freq <= 16'h0000;
         cfg.curve <= msp_pkg::MSP_CURVE_GP;
         cfg.therm_tc <= `MSP_RST_THERM_TC;
         cfg.oh_action <= 3'h0;
         cfg.filt_tc <= `MSP_RST_FILT_TC;
         cfg.fref_sel <= `MSP_RST_FREF;
         cfg.pid_sel <= 4'h0;
         cfg.pid_fb_sel <= 4'h0;
         serial_src <= 1'b0;
      end else if (ok_wr) begin
         case (wb_adr_i)
            `MSP_A_RATED_CUR: begin
               cfg.rated_cur[7:0] <= wd;
               if (wb_sel_i[1]) begin
                  cfg.rated_cur[15:8] <= wb_dat_i[15:8];
               end
            end
            `MSP_A_NOLOAD: begin
               cfg.noload_pct <= (wd > `MSP_NOLOAD_MAX) ? `MSP_NOLOAD_MAX : wd;
            end
            `MSP_A_SLIP: cfg.rated_slip <= wd;
            `MSP_A_GAIN: cfg.slip_gain <= wd;
            `MSP_A_SLIP_TC: cfg.slip_tc <= wd;
            `MSP_A_MIN_FREQ: begin
               cfg.min_freq[7:0] <= wd;
               if (wb_sel_i[1]) begin
                  cfg.min_freq[15:8] <= wb_dat_i[15:8];
               end
            end
            `MSP_A_CURVE: begin
               // code 3 falls back to no protection; only the low two bits are decoded
               if (wd[1:0] == 2'h3) begin
                  cfg.curve <= msp_pkg::MSP_CURVE_OFF;
               end else begin
                  cfg.curve <= msp_pkg::msp_curve_t'(wd[1:0]);
               end
            end
            `MSP_A_THERM_TC: begin
               if (wd == 8'h00) begin
                  cfg.therm_tc <= 6'h01;
               end else if (wd > 8'(`MSP_THERM_TC_MAX)) begin
                  cfg.therm_tc <= `MSP_THERM_TC_MAX;
               end else begin
                  cfg.therm_tc <= wd[5:0];
               end
            end
            `MSP_A_OH_ACT: cfg.oh_action <= wd[2:0];
            `MSP_A_FILT_TC: begin
               cfg.filt_tc <= (wd > 8'(`MSP_FILT_TC_MAX)) ?
                  `MSP_FILT_TC_MAX : wd[6:0];
            end
            `MSP_A_FREF: cfg.fref_sel <= wd[3:0];
            `MSP_A_PID: cfg.pid_sel <= wd[3:0];
            `MSP_A_PID_FB: cfg.pid_fb_sel <= wd[3:0];
            `MSP_A_SRC: serial_src <= wd[0];
            default: serial_src <= serial_src;
         endcase
      end
   end

   // refused-write flags, set wins over write-1-to-clear
   logic st_clr;
   logic bad_wr;
   assign st_clr = wr && wb_adr_i == `MSP_A_STATUS;
   assign bad_wr = wr & bad;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         constant_conflict_error_o <= 1'b0;
      end else if (bad_wr && serial_src) begin
         constant_conflict_error_o <= 1'b1;
      end else if (st_clr && wd[`MSP_ST_CONFLICT]) begin
         constant_conflict_error_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_error_o <= 1'b0;
      end else if (bad_wr && !serial_src) begin
         key_error_o <= 1'b1;
      end else if (st_clr && wd[`MSP_ST_KEY]) begin
         key_error_o <= 1'b0;
      end
   end

   // slip compensation

   logic [23:0] nl_prod;
   logic [15:0] nl_cur;
   logic slip_off;
   logic [15:0] excess;
   logic [15:0] span;
   logic [47:0] num;
   logic [47:0] quo;
   logic [15:0] slip_tgt;
   logic [7:0] slip_tc_eff;

   assign nl_prod = cfg.rated_cur * cfg.noload_pct;
   assign nl_cur = 16'(nl_prod / 24'd100);
   assign slip_off = out_freq_i < cfg.min_freq
      || regen_i
      || cfg.rated_cur == 16'h0;
   assign excess = (out_cur_i > nl_cur) ? out_cur_i - nl_cur : 16'h0;
   assign span = cfg.rated_cur - nl_cur;
   // gain is in tenths, so rated slip times gain over ten at rated current
   assign num = 48'(excess) * 48'(cfg.rated_slip) * 48'(cfg.slip_gain);
   assign quo = (span == 16'h0) ? 48'h0 : num / (48'(span) * 48'd10);

   always_comb begin
      if (slip_off || quo > 48'h00000000FFFF) begin
         slip_tgt = slip_off ? 16'h0 : 16'hFFFF;
      end else begin
         slip_tgt = quo[15:0];
      end
   end

   assign slip_tc_eff = (cfg.slip_tc == 8'h00) ? `MSP_SLIP_TC_ZERO : cfg.slip_tc;

   // q8 accumulator so small steps are not lost to truncation
   logic [23:0] slip_acc;
   logic signed [25:0] slip_diff;
   logic signed [25:0] slip_step;
   logic signed [25:0] slip_sum;

   assign slip_diff = $signed({2'b00, slip_tgt, 8'h00}) - $signed({2'b00, slip_acc});
   assign slip_step = slip_diff / $signed({18'h0, slip_tc_eff});
   assign slip_sum = $signed({2'b00, slip_acc}) + slip_step;

   always_ff @(posedge clk_i) begin
      if (rst_i || slip_off) begin
         slip_acc <= 24'h0;
      end else if (tick) begin
         slip_acc <= slip_sum[23:0];
      end
   end

   logic [16:0] freq_sum;
   assign freq_sum = {1'b0, out_freq_i} + {1'b0, slip_acc[23:8]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         slip_comp_o <= 16'h0;
         comp_freq_o <= 16'h0;
      end else begin
         slip_comp_o <= slip_acc[23:8];
         comp_freq_o <= freq_sum[16] ? 16'hFFFF : freq_sum[15:0];
      end
   end

   // electronic thermal overload

   logic ovl_on;
   logic [25:0] ratio_full;
   logic [9:0] ratio;
   logic [19:0] ratio_sq;
   logic [11:0] load;
   logic [15:0] n_ticks;
   logic [31:0] heat;
   logic [31:0] heat_loss;
   logic [11:0] lim;
   logic [27:0] trip_lvl;
   logic [32:0] heat_next;

   assign ovl_on = cfg.rated_cur != 16'h0
      && cfg.curve != msp_pkg::MSP_CURVE_OFF;
   assign ratio_full = (cfg.rated_cur == 16'h0) ? 26'h0 :
      {out_cur_i, 8'h00} * 26'h1 / {10'h0, cfg.rated_cur};
   assign ratio = (ratio_full > 26'(`MSP_RATIO_MAX)) ? `MSP_RATIO_MAX : ratio_full[9:0];
   assign ratio_sq = ratio * ratio;
   assign load = ratio_sq[19:8];
   assign n_ticks = 16'(cfg.therm_tc * `MSP_TICKS_PER_MIN);
   assign heat_loss = heat / {16'h0, n_ticks};
   assign lim = (cfg.curve == msp_pkg::MSP_CURVE_GP) ? `MSP_LIM_GP : `MSP_LIM_INV;
   assign trip_lvl = lim * n_ticks;
   assign heat_next = {1'b0, heat} + {21'h0, load} - {1'b0, heat_loss};

   always_ff @(posedge clk_i) begin
      if (rst_i || !ovl_on) begin
         heat <= 32'h0;
      end else if (tick) begin
         heat <= heat_next[32] ? 32'hFFFFFFFF : heat_next[31:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         motor_overload_fault_o <= 1'b0;
      end else if (ovl_on && heat > {4'h0, trip_lvl}) begin
         motor_overload_fault_o <= 1'b1;
      end else if (fault_reset_i) begin
         motor_overload_fault_o <= 1'b0;
      end
   end

   // thermistor filter, q4

   localparam int FW = ADC_W + 4;
   logic [FW-1:0] filt;
   logic signed [FW+1:0] f_diff;
   logic signed [FW+1:0] f_step;
   logic signed [FW+1:0] f_sum;
   logic [ADC_W-1:0] filt_v;

   assign f_diff = $signed({2'b00, thermistor_analog_input_i, 4'h0})
      - $signed({2'b00, filt});
   assign f_step = f_diff / $signed({(FW - 5)'(0), cfg.filt_tc});
   assign f_sum = $signed({2'b00, filt}) + f_step;
   assign filt_v = filt[FW-1:4];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filt <= '0;
      end else if (tick) begin
         if (cfg.filt_tc == 7'h0) begin
            filt <= {thermistor_analog_input_i, 4'h0};
         end else begin
            filt <= f_sum[FW-1:0];
         end
      end
   end

   // overheat supervision

   logic [2:0] act;
   logic act_alarm;
   logic act_stop;
   logic act_decel;
   logic act_coast;

   assign act = cfg.oh_action;
   assign act_alarm = act >= 3'h1 && act <= 3'h4;
   assign act_stop = act >= 3'h2;
   assign act_decel = act == 3'h2 || act == 3'h3 || act == 3'h5 || act == 3'h6;
   assign act_coast = act == 3'h4 || act == 3'h7;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         motor_overheat_alarm_o <= 1'b0;
      end else begin
         motor_overheat_alarm_o <= therm_on && act_alarm && filt_v > ALM_THR;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         motor_overheat_fault_o <= 1'b0;
      end else if (therm_on && act_stop && filt_v > FLT_THR) begin
         motor_overheat_fault_o <= 1'b1;
      end else if (fault_reset_i) begin
         motor_overheat_fault_o <= 1'b0;
      end
   end

   // stop commands follow the latched faults

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         decel_stop_o <= 1'b0;
         use_second_decel_o <= 1'b0;
         output_off_o <= 1'b0;
      end else begin
         decel_stop_o <= motor_overheat_fault_o && act_decel;
         use_second_decel_o <= motor_overheat_fault_o && act == 3'h3;
         output_off_o <= motor_overload_fault_o
            || (motor_overheat_fault_o && act_coast);
      end
   end

   // indicator flashing at a 0.5 s phase

   logic [2:0] flash_cnt;
   logic flash_ph;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flash_cnt <= 3'h0;
         flash_ph <= 1'b0;
      end else if (tick) begin
         if (flash_cnt == `MSP_FLASH_TICKS - 3'h1) begin
            flash_cnt <= 3'h0;
            flash_ph <= ~flash_ph;
         end else begin
            flash_cnt <= flash_cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alarm_flash_o <= 1'b0;
         fault_flash_o <= 1'b0;
         conflict_flash_o <= 1'b0;
      end else begin
         alarm_flash_o <= motor_overheat_alarm_o & flash_ph;
         fault_flash_o <= motor_overheat_fault_o & flash_ph;
         conflict_flash_o <= constant_conflict_error_o & flash_ph;
      end
   end

   // bus answer: ack one cycle after the request, unmapped reads zero

   logic [31:0] rd;

   always_comb begin
      case (wb_adr_i)
         `MSP_A_RATED_CUR: rd = {16'h0, cfg.rated_cur};
         `MSP_A_NOLOAD: rd = {24'h0, cfg.noload_pct};
         `MSP_A_SLIP: rd = {24'h0, cfg.rated_slip};
         `MSP_A_GAIN: rd = {24'h0, cfg.slip_gain};
         `MSP_A_SLIP_TC: rd = {24'h0, cfg.slip_tc};
         `MSP_A_MIN_FREQ: rd = {16'h0, cfg.min_freq};
         `MSP_A_CURVE: rd = {30'h0, cfg.curve};
         `MSP_A_THERM_TC: rd = {26'h0, cfg.therm_tc};
         `MSP_A_OH_ACT: rd = {29'h0, cfg.oh_action};
         `MSP_A_FILT_TC: rd = {25'h0, cfg.filt_tc};
         `MSP_A_FREF: rd = {28'h0, cfg.fref_sel};
         `MSP_A_PID: rd = {28'h0, cfg.pid_sel};
         `MSP_A_PID_FB: rd = {28'h0, cfg.pid_fb_sel};
         `MSP_A_STATUS: begin
            rd = {24'h0, output_off_o, use_second_decel_o, decel_stop_o,
               key_error_o, constant_conflict_error_o,
               motor_overheat_fault_o, motor_overheat_alarm_o,
               motor_overload_fault_o};
         end
         `MSP_A_SRC: rd = {31'h0, serial_src};
         `MSP_A_THERM_V: rd = {(32 - ADC_W)'(0), filt_v};
         `MSP_A_HEAT: rd = heat;
         default: rd = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= rd;
         end
      end
   end

endmodule // msp_top

`default_nettype wire

// ### msp_props.sv
`timescale 1ns/100ps
`default_nettype none
module msp_props (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [15:0] out_freq_i,
   input wire logic regen_i,
   input wire logic fault_reset_i,
   input wire logic [15:0] comp_freq_o,
   input wire logic [15:0] slip_comp_o,
   input wire logic output_off_o,
   input wire logic decel_stop_o,
   input wire logic use_second_decel_o,
   input wire logic motor_overload_fault_o,
   input wire logic motor_overheat_alarm_o,
   input wire logic motor_overheat_fault_o,
   input wire logic alarm_flash_o,
   input wire logic fault_flash_o,
   input wire logic constant_conflict_error_o,
   input wire logic conflict_flash_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [15:0] freq_q;
   logic [16:0] sum;
   always_ff @(posedge clk_i) freq_q <= out_freq_i;
   assign sum = {1'b0, freq_q} + {1'b0, slip_comp_o};

   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_comp_sum: assert property (
      !$past(rst_i) |-> comp_freq_o == (sum[16] ? 16'hFFFF : sum[15:0]))
      else $error("comp freq wrong");
   a_regen_zero: assert property (
      regen_i ##1 regen_i |=> slip_comp_o == 16'h0000)
      else $error("slip while regenerating");
   a_ovl_off: assert property ($rose(motor_overload_fault_o) |-> ##[0:1] output_off_o)
      else $error("output not off");
   a_ovl_latch: assert property (
      motor_overload_fault_o && !fault_reset_i |=> motor_overload_fault_o)
      else $error("overload lost");
   a_oh_latch: assert property (
      motor_overheat_fault_o && !fault_reset_i |=> motor_overheat_fault_o)
      else $error("overheat fault lost");
   a_oh_stop: assert property (
      motor_overheat_fault_o |=> decel_stop_o || output_off_o)
      else $error("no stop on fault");
   a_decel2_sub: assert property (use_second_decel_o |-> decel_stop_o)
      else $error("second decel alone");
   a_alarm_flash: assert property (
      alarm_flash_o |-> motor_overheat_alarm_o || $past(motor_overheat_alarm_o))
      else $error("alarm flash without alarm");
   a_fault_flash: assert property (
      fault_flash_o |-> motor_overheat_fault_o || $past(motor_overheat_fault_o))
      else $error("fault flash without fault");
   a_conf_flash: assert property (
      conflict_flash_o |-> constant_conflict_error_o || $past(constant_conflict_error_o))
      else $error("conflict flash without error");
endmodule // msp_props

bind msp_top msp_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .out_freq_i(out_freq_i), .regen_i(regen_i),
   .fault_reset_i(fault_reset_i), .comp_freq_o(comp_freq_o), .slip_comp_o(slip_comp_o),
   .output_off_o(output_off_o), .decel_stop_o(decel_stop_o),
   .use_second_decel_o(use_second_decel_o), .motor_overload_fault_o(motor_overload_fault_o),
   .motor_overheat_alarm_o(motor_overheat_alarm_o),
   .motor_overheat_fault_o(motor_overheat_fault_o), .alarm_flash_o(alarm_flash_o),
   .fault_flash_o(fault_flash_o),
   .constant_conflict_error_o(constant_conflict_error_o), .conflict_flash_o(conflict_flash_o));
`default_nettype wire

// ### msp_motor.sv
`timescale 1ns/100ps
`default_nettype none
module msp_motor #(
   parameter int FS_MV = 10000
) (
   input wire logic clk_i,
   input wire logic [15:0] load_i,
   input wire logic [13:0] temp_mv_i,
   output logic [15:0] cur_o,
   output logic [11:0] therm_o
);
   // stator current lags the load by a cycle
   always_ff @(posedge clk_i) cur_o <= load_i;
   // series sensors seen through a 12-bit converter, truncating
   always_ff @(posedge clk_i) therm_o <= 12'(32'(temp_mv_i) * 4096 / FS_MV);
endmodule // msp_motor
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "msp_regs.svh"
module testbench;
   logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, regen = 0, frst = 0, ack;
   logic off, dec, dec2, ovl, alm, flt, cerr, kerr;
   logic [7:0] adr = 0;
   logic [31:0] wdat = 0, rdat, rd;
   logic [15:0] freq = 0, load = 0, cur, comp, slip;
   logic [13:0] mv = 0;
   logic [11:0] therm;
   int n_fail = 0, compares = 0;

   msp_motor i_motor (.clk_i(clk_i), .load_i(load), .temp_mv_i(mv), .cur_o(cur),
      .therm_o(therm));
   msp_top #(.TICK_CYC(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
      .wb_dat_o(rdat), .wb_ack_o(ack), .out_freq_i(freq), .out_cur_i(cur),
      .regen_i(regen), .thermistor_analog_input_i(therm), .fault_reset_i(frst),
      .comp_freq_o(comp), .slip_comp_o(slip), .output_off_o(off), .decel_stop_o(dec),
      .use_second_decel_o(dec2), .motor_overload_fault_o(ovl),
      .motor_overheat_alarm_o(alm), .motor_overheat_fault_o(flt), .alarm_flash_o(),
      .fault_flash_o(), .constant_conflict_error_o(cerr), .conflict_flash_o(),
      .key_error_o(kerr));

   initial forever #4 clk_i = ~clk_i;

   task automatic wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic wt(input int c);
      repeat (c) @(posedge clk_i);
   endtask

   // cyc doubles as stb: they rise and fall together
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         c++;
      end while (ack !== 1'b1 && c < 20);
      if (c >= 20) n_fail++;
      rd = rdat;
      cyc <= 1'b0;
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s exp %h got %h", s, e, g);
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
      bus(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask

   // {off, second decel, decel, alarm} once the fault has latched
   function automatic logic [3:0] oh_exp(input int c);
      return {c == 4 || c == 7, c == 3, c == 2 || c == 3 || c == 5 || c == 6, c >= 1 && c <= 4};
   endfunction

   initial begin
      wt(60000);
      n_fail++;
      wrap_up;
   end

   initial begin
      logic [15:0] f;
      int c;
      void'($urandom(32'hF17B));
      wt(6);
      rst_i <= 1'b0;
      rc(`MSP_A_SLIP_TC, 32'h14, "slip_tc");
      rc(`MSP_A_FILT_TC, 32'h2, "filt_tc");
      rc(`MSP_A_THERM_TC, 32'h8, "therm_tc");
      rc(8'hFC, 32'h0, "unmapped");
      $display("test reset done");
      bus(1'b1, `MSP_A_FILT_TC, 32'h0);
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, `MSP_A_OH_ACT, k);
         mv <= 14'($urandom % 900);
         wt(50);
         chk("oh_low", 32'h0, {alm, flt});
         mv <= 14'(950 + $urandom % 900);
         wt(50);
         chk("oh_mid", oh_exp(k) & 4'h1, {flt, alm});
         mv <= 14'(1900 + $urandom % 8000);
         wt(50);
         chk("oh_high", {k >= 2, oh_exp(k)}, {flt, off, dec2, dec, alm});
         mv <= 14'h0;
         wt(50);
         chk("oh_latch", k >= 2, flt);
         frst <= 1'b1;
         wt(2);
         frst <= 1'b0;
         wt(3);
         chk("oh_clr", 32'h0, {flt, dec, off});
      end
      $display("test thermistor done");
      for (int s = 0; s < 2; s++) begin
         for (int k = 2; k < 5; k++) begin
            bus(1'b1, `MSP_A_SRC, s);
            bus(1'b1, `MSP_A_FREF, k);
            rc(`MSP_A_FREF, 32'h1, "fref");
            chk("err", s ? 32'h2 : 32'h1, {cerr, kerr});
            bus(1'b1, `MSP_A_STATUS, 32'h18);
            wt(2);
            chk("err_clr", 32'h0, {cerr, kerr});
         end
      end
      bus(1'b1, `MSP_A_PID_FB, 32'h5);
      bus(1'b1, `MSP_A_PID, 32'h1);
      for (int b = 0; b < 3; b++) begin
         bus(1'b1, `MSP_A_PID_FB, b);
         rc(`MSP_A_PID_FB, 32'h5, "pid_fb");
      end
      bus(1'b1, `MSP_A_OH_ACT, 32'h0);
      bus(1'b1, `MSP_A_PID_FB, 32'h1);
      bus(1'b1, `MSP_A_OH_ACT, 32'h2);
      rc(`MSP_A_OH_ACT, 32'h0, "oh_pid");
      bus(1'b1, `MSP_A_PID, 32'h0);
      bus(1'b1, `MSP_A_FREF, 32'h3);
      bus(1'b1, `MSP_A_OH_ACT, 32'h2);
      rc(`MSP_A_OH_ACT, 32'h0, "oh_fref");
      $display("test interlock done");
      bus(1'b1, `MSP_A_RATED_CUR, 32'h64);
      bus(1'b1, `MSP_A_NOLOAD, 32'h1E);
      bus(1'b1, `MSP_A_SLIP, 32'h32);
      bus(1'b1, `MSP_A_GAIN, 32'hA);
      bus(1'b1, `MSP_A_SLIP_TC, 32'h1);
      bus(1'b1, `MSP_A_MIN_FREQ, 32'h64);
      f = 16'(100 + $urandom % 30000);
      freq <= f;
      load <= 16'h64;
      wt(60);
      chk("slip_full", 32'h32, slip);
      chk("comp", f + 32'h32, comp);
      load <= 16'h41;
      wt(60);
      chk("slip_half", 32'h19, slip);
      freq <= 16'h63;
      wt(5);
      chk("slip_min", 32'h0, slip);
      freq <= f;
      regen <= 1'b1;
      wt(5);
      chk("slip_regen", 32'h0, slip);
      regen <= 1'b0;
      bus(1'b1, `MSP_A_RATED_CUR, 32'h0);
      wt(5);
      chk("slip_norated", 32'h0, slip);
      $display("test slip done");
      bus(1'b1, `MSP_A_RATED_CUR, 32'hA);
      bus(1'b1, `MSP_A_THERM_TC, 32'h1);
      load <= 16'h07D0;
      for (int k = 1; k >= 0; k--) begin
         // curve off empties the model so each curve trips from cold
         bus(1'b1, `MSP_A_CURVE, 32'h2);
         frst <= 1'b1;
         wt(2);
         frst <= 1'b0;
         wt(2);
         chk("ovl_clr", 32'h0, ovl);
         bus(1'b1, `MSP_A_CURVE, k);
         c = 0;
         while (ovl !== 1'b1 && c < 3000) begin
            wt(1);
            c++;
         end
         wt(2);
         chk("ovl", 32'h3, {ovl, off});
      end
      bus(1'b1, `MSP_A_CURVE, 32'h2);
      frst <= 1'b1;
      wt(2);
      frst <= 1'b0;
      wt(300);
      chk("ovl_curve_off", 32'h0, ovl);
      bus(1'b1, `MSP_A_CURVE, 32'h0);
      bus(1'b1, `MSP_A_RATED_CUR, 32'h0);
      frst <= 1'b1;
      wt(2);
      frst <= 1'b0;
      wt(300);
      chk("ovl_norated", 32'h0, ovl);
      $display("test thermal done");
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
